// ===== verilog/urir_consts.vh
// Constants for the serial transceiver core with infrared encoder/decoder
`ifndef URIR_CONSTS_VH
`define URIR_CONSTS_VH
`define URIR_IDIV_W 16
`define URIR_FDIV_W 6
`define URIR_OVS 5'h10
`define URIR_MID_UART 4'h7
`define URIR_MID_IR 4'h3
`define URIR_IR_PULSE 5'h03
`define URIR_FIFO_DEPTH 32
`define URIR_FIFO_AW 5
`define URIR_RXE_FRM 8
`define URIR_RXE_PAR 9
`define URIR_RXE_BRK 10
`define URIR_RXE_OVR 11
`define URIR_LP_DIV_RST 8'h01
`endif

// ===== verilog/urir_core.v
// Serial transceiver core: fractional bit-rate, framing, FIFOs, loopback, infrared coder
// Contract
// (RULE_01) 22-bit divisor: 16 integer, 6 fraction bits
// (RULE_02) Divisor is refclk over sixteen times rate
// (RULE_03) Software rounds fraction times 64 plus half
// (RULE_04) Oversample tick pulses; divide by sixteen
// (RULE_05) Two 32-entry FIFOs, receive adds status
// (RULE_06) Enabled transmitter sends until FIFO empty
// (RULE_07) Busy until FIFO empty and stop sent
// (RULE_08) Three samples per bit, majority vote
// (RULE_09) Sample at tick eight, four in infrared
// (RULE_10) Start valid only if still low
// (RULE_11) Data bits every sixteen ticks, then parity
// (RULE_12) Stop low flags framing; store word
// (RULE_13) Entry: data, frame, parity, break, overrun
// (RULE_14) Full FIFO: set overrun, drop character
// (RULE_15) Next stored character carries overrun, then clear
// (RULE_16) FIFOs off: one-entry holding, overrun on unread
// (RULE_17) FIFOs off: write bypasses to shifter
// (RULE_18) Loopback routes transmit to receive internally
// (RULE_19) Infrared zero is 3/16 high pulse
// (RULE_20) Low-power pulse is three low-power ticks
// (RULE_21) Low-power tick from divisor, 1.42-2.12MHz
// (RULE_22) Loopback plus test loops infrared path
// (RULE_23) Decoder rejects low pulses under 3/16
// (RULE_24) Decoded bits feed normal receive logic
`timescale 1ns/10ps
`include "urir_consts.vh"
module urir_core #(
  parameter FDEPTH = `URIR_FIFO_DEPTH,
  parameter AW = `URIR_FIFO_AW
) (
  input wire i_ref_clk, // Reference clock, 40 MHz
  input wire i_rst, // Asynchronous reset, active high
  input wire [15:0] i_integer_divisor_reg, // Integer divisor part
  input wire [5:0] i_fraction_divisor_reg, // Fractional divisor part
  input wire [7:0] i_ir_lowpower_divisor_reg, // Low-power tick divisor
  input wire i_enable, // Transceiver enable
  input wire i_tx_enable, // Transmit enable
  input wire i_rx_enable, // Receive enable
  input wire [1:0] i_word_len, // 0..3 means 5..8 data bits
  input wire i_parity_en, // Parity enable
  input wire i_parity_even, // Even parity
  input wire i_parity_stick, // Stick parity
  input wire i_two_stop, // Two stop bits
  input wire i_send_break, // Hold line low
  input wire i_fifo_en, // FIFOs enabled
  input wire i_ir_en, // Infrared mode
  input wire i_ir_lowpower_select, // Low-power pulse width
  input wire i_loopback_enable, // Internal loopback
  input wire i_ir_test_loop, // Infrared loopback with loopback_enable
  input wire [7:0] i_tx_data, // Transmit character
  input wire i_tx_valid, // Transmit character offered
  output wire o_tx_ready, // Transmit buffer can take it
  output wire [11:0] o_rx_data, // Received entry with status
  output wire o_rx_valid, // Entry available
  input wire i_rx_ready, // Consumer takes the entry
  input wire i_serial_rx_in, // Serial line in
  input wire i_ir_rx_in, // Infrared detector in, idle high
  output reg o_serial_tx_out, // Serial line out
  output reg o_ir_tx_out_n, // Infrared driver out
  output wire o_busy, // Transmitter busy
  output reg o_overrun_pending // Overrun waiting for next entry
);
  localparam TS_IDLE = 3'd0;
  localparam TS_START = 3'd1;
  localparam TS_DATA = 3'd2;
  localparam TS_PAR = 3'd3;
  localparam TS_STOP = 3'd4;

  function par_of;
    input [7:0] d;
    input [1:0] wl;
    input ev;
    input st;
    reg p;
    begin
      p = ^(d & (8'hff >> (2'd3 - wl)));
      par_of = st ? ~ev : (ev ? p : ~p);
    end
  endfunction

  // Fractional generator: 64x accumulator, tick every divisor (RULE_01) (RULE_02)
  reg [21:0] bd_cnt_r;
  reg [5:0] bd_frac_r;
  reg tick_r;
  wire [6:0] frac_sum = {1'b0, bd_frac_r} + {1'b0, i_fraction_divisor_reg};
  wire [21:0] bd_top = {6'h00, i_integer_divisor_reg} + {21'h0, frac_sum[6]};
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bd_cnt_r <= 22'h00_0000;
      bd_frac_r <= 6'h00;
      tick_r <= 1'b0;
    end else if (!i_enable || i_integer_divisor_reg == 16'h0000) begin
      bd_cnt_r <= 22'h00_0000;
      tick_r <= 1'b0;
    end else if (bd_cnt_r + 22'h00_0001 >= bd_top) begin
      bd_cnt_r <= 22'h00_0000;
      bd_frac_r <= frac_sum[5:0];
      tick_r <= 1'b1; // RULE_04
    end else begin
      bd_cnt_r <= bd_cnt_r + 22'h00_0001;
      tick_r <= 1'b0;
    end
  end

  // Low-power timebase (RULE_21)
  reg [7:0] lp_cnt_r;
  reg lp_tick_r;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lp_cnt_r <= 8'h00;
      lp_tick_r <= 1'b0;
    end else if (lp_cnt_r + 8'h01 >= i_ir_lowpower_divisor_reg) begin
      lp_cnt_r <= 8'h00;
      lp_tick_r <= (i_ir_lowpower_divisor_reg != 8'h00); // RULE_21
    end else begin
      lp_cnt_r <= lp_cnt_r + 8'h01;
      lp_tick_r <= 1'b0;
    end
  end

  // Transmit FIFO; depth one when FIFOs are off (RULE_05) (RULE_16)
  reg [7:0] txm [0:FDEPTH-1];
  reg [AW:0] tx_cnt_r;
  reg [AW-1:0] tx_wp_r, tx_rp_r;
  reg [2:0] ts_r;
  wire tx_full = i_fifo_en ? (tx_cnt_r == FDEPTH) : (tx_cnt_r != 0);
  assign o_tx_ready = !tx_full;
  wire tx_push = i_tx_valid && !tx_full;
  wire tx_pop = (ts_r == TS_IDLE) && (tx_cnt_r != 0) && i_enable && i_tx_enable;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_cnt_r <= {(AW+1){1'b0}};
      tx_wp_r <= {AW{1'b0}};
      tx_rp_r <= {AW{1'b0}};
    end else begin
      if (tx_push) begin
        txm[tx_wp_r] <= i_tx_data;
        tx_wp_r <= tx_wp_r + 1'b1;
      end
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
    end
  end

  // Transmitter; with FIFOs off an idle shifter empties the holding entry at once (RULE_17)
  reg [7:0] tsh_r;
  reg [3:0] t16_r;
  reg [2:0] tbit_r;
  reg tstop2_r;
  reg tx_nrz_r;
  assign o_busy = (tx_cnt_r != 0) || (ts_r != TS_IDLE); // RULE_07
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ts_r <= TS_IDLE;
      tsh_r <= 8'h00;
      t16_r <= 4'h0;
      tbit_r <= 3'd0;
      tstop2_r <= 1'b0;
      tx_nrz_r <= 1'b1;
    end else begin
      case (ts_r)
        TS_IDLE: begin
          tx_nrz_r <= 1'b1;
          if (tx_pop) begin // RULE_06
            tsh_r <= txm[tx_rp_r];
            ts_r <= TS_START;
            t16_r <= 4'h0;
            tx_nrz_r <= 1'b0;
          end
        end
        default: begin
          if (tick_r) begin
            t16_r <= t16_r + 4'h1;
            if (t16_r == 4'hf) begin // RULE_04
              case (ts_r)
                TS_START: begin
                  ts_r <= TS_DATA;
                  tbit_r <= 3'd0;
                  tx_nrz_r <= tsh_r[0];
                end
                TS_DATA: begin
                  if (tbit_r == {1'b1, i_word_len}) begin
                    ts_r <= i_parity_en ? TS_PAR : TS_STOP;
                    tx_nrz_r <= i_parity_en ?
                      par_of(tsh_r, i_word_len, i_parity_even, i_parity_stick) : 1'b1;
                    tstop2_r <= i_two_stop;
                  end else begin
                    tbit_r <= tbit_r + 3'd1;
                    tx_nrz_r <= tsh_r[tbit_r + 3'd1];
                  end
                end
                TS_PAR: begin
                  ts_r <= TS_STOP;
                  tx_nrz_r <= 1'b1;
                end
                TS_STOP: begin
                  if (tstop2_r)
                    tstop2_r <= 1'b0;
                  else
                    ts_r <= TS_IDLE;
                end
                default: ts_r <= TS_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end

  // Infrared encoder: pulse for each zero (RULE_19) (RULE_20)
  reg [4:0] ir_pw_r;
  reg ir_on_r;
  wire pw_tick = i_ir_lowpower_select ? lp_tick_r : tick_r;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_pw_r <= 5'h00;
      ir_on_r <= 1'b0;
    end else if (ts_r != TS_IDLE && tick_r && t16_r == 4'h0 && !tx_nrz_r) begin
      ir_on_r <= 1'b1;
      ir_pw_r <= 5'h00;
    end else if (ir_on_r && pw_tick) begin
      ir_pw_r <= ir_pw_r + 5'h01;
      if (ir_pw_r + 5'h01 >= `URIR_IR_PULSE)
        ir_on_r <= 1'b0; // RULE_20
    end
  end
  wire ir_enc = i_ir_en && ir_on_r && i_enable;
  wire line_tx = tx_nrz_r && !i_send_break;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_tx_out <= 1'b1;
      o_ir_tx_out_n <= 1'b0;
    end else begin
      o_serial_tx_out <= i_loopback_enable ? 1'b1 : line_tx;
      o_ir_tx_out_n <= i_loopback_enable ? 1'b0 : ir_enc; // RULE_22
    end
  end

  // Input synchronisers
  reg [1:0] srx_s_r, irx_s_r;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      srx_s_r <= 2'b11;
      irx_s_r <= 2'b11;
    end else begin
      srx_s_r <= {srx_s_r[0], i_serial_rx_in};
      irx_s_r <= {irx_s_r[0], i_ir_rx_in};
    end
  end
  // Infrared decoder: a detector low longer than 3/16 of a tick stretches to a zero bit
  wire ir_in = (i_loopback_enable && i_ir_test_loop) ? !ir_enc : irx_s_r[1]; // RULE_22
  reg [21:0] glt_r;
  reg [4:0] dec_r;
  reg ir_nrz_r;
  wire [21:0] tick_len = i_ir_lowpower_select ? {14'h0000, i_ir_lowpower_divisor_reg} :
                         {6'h00, i_integer_divisor_reg};
  wire [21:0] glt_min = (tick_len * 22'd3) >> 4;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      glt_r <= 22'h00_0000;
      dec_r <= 5'h00;
      ir_nrz_r <= 1'b1;
    end else begin
      glt_r <= ir_in ? 22'h00_0000 : glt_r + 22'h00_0001;
      if (!ir_in && glt_r >= glt_min) begin // RULE_23
        ir_nrz_r <= 1'b0;
        dec_r <= 5'h00;
      end else if (!ir_nrz_r && tick_r) begin
        dec_r <= dec_r + 5'h01;
        if (dec_r == 5'h0f)
          ir_nrz_r <= 1'b1;
      end
    end
  end
  wire loop_rx = i_ir_en ? !ir_enc : line_tx;
  wire rxd = i_loopback_enable ? (i_ir_en ? ir_nrz_r : loop_rx) :
             (i_ir_en ? ir_nrz_r : srx_s_r[1]); // RULE_18 RULE_24

  // Receiver with three-sample majority (RULE_08)
  reg [2:0] rs_r;
  reg [3:0] r16_r;
  reg [2:0] rbit_r;
  reg [7:0] rsh_r;
  reg [1:0] maj_r;
  reg rperr_r;
  reg rdone_r;
  reg [10:0] rword_r;
  wire [3:0] mid = i_ir_en ? `URIR_MID_IR : `URIR_MID_UART; // RULE_09
  // Third sample is the live input, so no sample of the previous bit joins the vote
  wire vote = (maj_r[0] & maj_r[1]) | (maj_r[1] & rxd) | (maj_r[0] & rxd);
  wire smp = tick_r && (r16_r == mid + 4'h2);
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rs_r <= TS_IDLE;
      r16_r <= 4'h0;
      rbit_r <= 3'd0;
      rsh_r <= 8'h00;
      maj_r <= 2'b11;
      rperr_r <= 1'b0;
      rdone_r <= 1'b0;
      rword_r <= 11'h000;
    end else begin
      rdone_r <= 1'b0;
      if (tick_r && r16_r >= mid && r16_r <= mid + 4'h2)
        maj_r <= {maj_r[0], rxd};
      if (rs_r == TS_IDLE) begin
        r16_r <= 4'h0;
        if (!rxd && i_enable && i_rx_enable) // RULE_09
          rs_r <= TS_START;
      end else if (tick_r) begin
        r16_r <= r16_r + 4'h1;
        if (smp) begin
          case (rs_r)
            TS_START: begin
              rs_r <= vote ? TS_IDLE : TS_DATA; // RULE_10
              rbit_r <= 3'd0;
              rsh_r <= 8'h00;
            end
            TS_DATA: begin // RULE_11
              rsh_r[rbit_r] <= vote;
              rbit_r <= rbit_r + 3'd1;
              if (rbit_r == {1'b1, i_word_len})
                rs_r <= i_parity_en ? TS_PAR : TS_STOP;
            end
            TS_PAR: begin
              rperr_r <= vote != par_of(rsh_r, i_word_len, i_parity_even, i_parity_stick);
              rs_r <= TS_STOP;
            end
            default: begin // RULE_12
              rword_r <= {(rsh_r == 8'h00) && !vote, rperr_r && i_parity_en, !vote, rsh_r};
              rdone_r <= 1'b1;
              rperr_r <= 1'b0;
              rs_r <= TS_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Receive FIFO: the head entry drives the two-entry output stage (RULE_05) (RULE_13)
  reg [11:0] rxm [0:FDEPTH-1];
  reg [AW:0] rx_cnt_r;
  reg [AW-1:0] rx_wp_r, rx_rp_r;
  reg [11:0] ob_d0_r, ob_d1_r;
  reg [1:0] ob_n_r;
  wire rx_full = i_fifo_en ? (rx_cnt_r == FDEPTH) : (rx_cnt_r != 0 || ob_n_r != 2'd0);
  wire rx_push = rdone_r && !rx_full;
  wire ob_pop = (ob_n_r != 2'd0) && i_rx_ready;
  wire ob_take = (rx_cnt_r != 0) && (ob_n_r != 2'd2 || ob_pop);
  assign o_rx_valid = (ob_n_r != 2'd0);
  assign o_rx_data = ob_d0_r;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt_r <= {(AW+1){1'b0}};
      rx_wp_r <= {AW{1'b0}};
      rx_rp_r <= {AW{1'b0}};
      o_overrun_pending <= 1'b0;
      ob_d0_r <= 12'h000;
      ob_d1_r <= 12'h000;
      ob_n_r <= 2'd0;
    end else begin
      if (rdone_r && rx_full)
        o_overrun_pending <= 1'b1; // RULE_14 RULE_16
      else if (rx_push)
        o_overrun_pending <= 1'b0; // RULE_15
      if (rx_push) begin
        rxm[rx_wp_r] <= {o_overrun_pending, rword_r};
        rx_wp_r <= rx_wp_r + 1'b1;
      end
      if (ob_take)
        rx_rp_r <= rx_rp_r + 1'b1;
      rx_cnt_r <= rx_cnt_r + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, ob_take};
      case ({ob_take, ob_pop})
        2'b10: begin
          if (ob_n_r == 2'd0)
            ob_d0_r <= rxm[rx_rp_r];
          else
            ob_d1_r <= rxm[rx_rp_r];
          ob_n_r <= ob_n_r + 2'd1;
        end
        2'b01: begin
          ob_d0_r <= ob_d1_r;
          ob_n_r <= ob_n_r - 2'd1;
        end
        2'b11: begin
          if (ob_n_r == 2'd1)
            ob_d0_r <= rxm[rx_rp_r];
          else begin
            ob_d0_r <= ob_d1_r;
            ob_d1_r <= rxm[rx_rp_r];
          end
        end
        default: ob_n_r <= ob_n_r;
      endcase
    end
  end
endmodule // urir_core

// ===== testbench/urir_core_checker.sv
// Port-level assertions for the serial transceiver core
`timescale 1ns/10ps
module urir_core_checker (
  input wire i_ref_clk, // Clock
  input wire i_rst, // Reset
  input wire [15:0] i_integer_divisor_reg, // Integer divisor
  input wire [5:0] i_fraction_divisor_reg, // Fraction divisor
  input wire i_ir_lowpower_select, // Low-power pulse
  input wire i_loopback_enable, // Loopback
  input wire i_send_break, // Break
  input wire i_tx_valid, // Push offered
  input wire o_tx_ready, // Push accepted
  input wire [11:0] o_rx_data, // Receive entry
  input wire o_rx_valid, // Entry available
  input wire i_rx_ready, // Entry taken
  input wire o_serial_tx_out, // Serial out
  input wire o_ir_tx_out_n, // Infrared out
  input wire o_busy, // Busy
  input wire o_overrun_pending // Overrun waiting
);
  reg [7:0] ir_hi_r;
  // Length of the current infrared pulse in clocks
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_hi_r <= 8'h00;
    end else begin
      ir_hi_r <= o_ir_tx_out_n ? ir_hi_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_busy_after_push: assert property (i_tx_valid && o_tx_ready |=> o_busy)
    else $error("busy did not rise after a push");
  a_stop_before_idle: assert property ($fell(o_busy) |-> o_serial_tx_out && $past(o_serial_tx_out))
    else $error("busy fell before the stop bit");
  a_idle_line_high: assert property (!o_busy && !i_send_break && !$past(i_send_break)
    |-> o_serial_tx_out)
    else $error("line low while not busy");
  a_rx_entry_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("receive entry lost while stalled");
  a_ready_when_empty: assert property (!o_busy |-> o_tx_ready)
    else $error("transmit refused while empty");
  a_overrun_needs_full: assert property ($rose(o_overrun_pending) |-> o_rx_valid)
    else $error("overrun raised with space left");
  a_loop_serial_high: assert property (i_loopback_enable && $past(i_loopback_enable) && !i_send_break
    |-> o_serial_tx_out)
    else $error("serial out moved during loopback");
  a_loop_ir_low: assert property (i_loopback_enable && $past(i_loopback_enable) |-> !o_ir_tx_out_n)
    else $error("infrared out moved during loopback");
  a_ir_pulse_len: assert property (!i_ir_lowpower_select && i_fraction_divisor_reg == 6'h00
    |-> ir_hi_r <= 3 * i_integer_divisor_reg)
    else $error("infrared pulse too long");
  c_push: cover property (i_tx_valid && o_tx_ready);
  c_overrun: cover property ($rose(o_overrun_pending));
  c_frame_err: cover property (o_rx_valid && i_rx_ready && o_rx_data[8]);
endmodule // urir_core_checker
bind urir_core urir_core_checker i_chk (.*);

// ===== testbench/urir_remote.sv
// Remote serial device model: drives and decodes the serial line
`timescale 1ns/10ps
module urir_remote #(
  parameter BIT = 32
) (
  input wire i_ref_clk, // Clock
  input wire i_line_in, // From block serial out
  output reg o_line_out // To block serial in, idle high
);
  initial o_line_out = 1'b1;
  // Whole frame: start, data LSB first, optional parity, one stop
  task send(input [7:0] d, input pe, input pb, input sb);
    integer i;
    reg [10:0] f;
    begin
      f = {sb, pb, d, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        if (i != 9 || pe) begin
          @(posedge i_ref_clk) o_line_out <= f[i];
          repeat (BIT - 1) @(posedge i_ref_clk);
        end
      end
      @(posedge i_ref_clk) o_line_out <= 1'b1;
      repeat (BIT) @(posedge i_ref_clk);
    end
  endtask
  // Short low glitch, shorter than half a bit
  task pulse(input integer n);
    begin
      @(posedge i_ref_clk) o_line_out <= 1'b0;
      repeat (n) @(posedge i_ref_clk);
      o_line_out <= 1'b1;
      repeat (4 * BIT) @(posedge i_ref_clk);
    end
  endtask
  // Samples mid-bit; ok is low on no start or a low stop bit
  task recv(input integer nb, output [7:0] d, output ok);
    integer i;
    begin
      d = 8'h00;
      ok = 1'b0;
      for (i = 0; i < 4000 && !ok; i = i + 1) begin
        @(negedge i_ref_clk);
        ok = !i_line_in;
      end
      repeat (BIT / 2) @(negedge i_ref_clk);
      ok = ok & !i_line_in;
      for (i = 0; i < nb; i = i + 1) begin
        repeat (BIT) @(negedge i_ref_clk);
        d[i] = i_line_in;
      end
      repeat (BIT) @(negedge i_ref_clk);
      ok = ok & i_line_in;
    end
  endtask
endmodule // urir_remote

// ===== testbench/tb_urir_core.sv
// Self-checking bench for the serial transceiver core
`timescale 1ns/10ps
module tb_urir_core;
  localparam BIT = 32;
  reg i_ref_clk = 1'b0;
  reg i_rst = 1'b1;
  // Divisor 2.0 gives 1.25 Mbit/s at 40 MHz, fraction rounds to 0
  reg [15:0] i_integer_divisor_reg = 16'h0002;
  reg [5:0] i_fraction_divisor_reg = 6'h00;
  // 40 MHz / 22 keeps the low-power tick near 1.82 MHz
  reg [7:0] i_ir_lowpower_divisor_reg = 8'h16;
  reg i_enable = 1'b1, i_tx_enable = 1'b1, i_rx_enable = 1'b1;
  reg [1:0] i_word_len = 2'h3;
  reg i_parity_en = 1'b0, i_parity_even = 1'b1, i_fifo_en = 1'b1;
  reg i_ir_en = 1'b0, i_ir_lowpower_select = 1'b0;
  reg i_loopback_enable = 1'b0, i_ir_test_loop = 1'b0;
  reg [7:0] i_tx_data = 8'h00;
  reg i_tx_valid = 1'b0, i_rx_ready = 1'b0;
  reg i_parity_stick = 1'b0, i_two_stop = 1'b0, i_send_break = 1'b0, i_ir_rx_in = 1'b1;
  wire i_serial_rx_in, o_tx_ready, o_rx_valid, o_serial_tx_out, o_ir_tx_out_n;
  wire o_busy, o_overrun_pending;
  wire [11:0] o_rx_data;
  integer n_errors = 0;
  integer tests_run = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  urir_core i_dut (.*);
  urir_remote #(.BIT(BIT)) i_far (.i_ref_clk(i_ref_clk), .i_line_in(o_serial_tx_out),
    .o_line_out(i_serial_rx_in));
  task check(input [8*12-1:0] nm, input [11:0] got, input [11:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task stall;
    begin
      n_errors = n_errors + 1;
      $display("wrong value wait expected done seen timeout");
      test_done;
    end
  endtask
  task push(input [7:0] b);
    integer k;
    begin
      @(posedge i_ref_clk) i_tx_data <= b;
      i_tx_valid <= 1'b1;
      k = 0;
      @(negedge i_ref_clk);
      while (o_tx_ready !== 1'b1 && k < 4000) begin
        @(negedge i_ref_clk);
        k = k + 1;
      end
      if (k == 4000) stall;
      @(posedge i_ref_clk) i_tx_valid <= 1'b0;
    end
  endtask
  task pop(input [11:0] exp, input [11:0] m);
    integer k;
    begin
      k = 0;
      @(negedge i_ref_clk);
      while (o_rx_valid !== 1'b1 && k < 8000) begin
        @(negedge i_ref_clk);
        k = k + 1;
      end
      if (k == 8000) stall;
      check("rx entry", o_rx_data & m, exp);
      @(posedge i_ref_clk) i_rx_ready <= 1'b1;
      @(posedge i_ref_clk) i_rx_ready <= 1'b0;
    end
  endtask
  task wait_idle;
    integer k;
    begin
      k = 0;
      @(negedge i_ref_clk);
      while (o_busy !== 1'b0 && k < 20000) begin
        @(negedge i_ref_clk);
        k = k + 1;
      end
      if (k == 20000) stall;
    end
  endtask
  task t_tx;
    reg [7:0] d;
    reg ok;
    integer w;
    begin
      for (w = 0; w < 4; w = w + 1) begin
        @(posedge i_ref_clk) i_word_len <= w[1:0];
        fork
          begin
            push(8'hA5);
            push(8'h3C);
          end
          begin
            i_far.recv(w + 5, d, ok);
            check("tx first", {3'h0, ok, d}, {4'h1, 8'hA5 & (8'hFF >> (3 - w))});
            i_far.recv(w + 5, d, ok);
            check("tx second", {3'h0, ok, d}, {4'h1, 8'h3C & (8'hFF >> (3 - w))});
            check("busy", {11'h000, o_busy}, 12'h001);
          end
        join
        wait_idle;
      end
      $display("transmit framing done");
    end
  endtask
  task t_rx;
    begin
      i_far.pulse(4);
      check("glitch", {11'h000, o_rx_valid}, 12'h000);
      i_far.send(8'h5A, 1'b0, 1'b0, 1'b1);
      pop(12'h05A, 12'hFFF);
      i_far.send(8'h81, 1'b0, 1'b0, 1'b0);
      pop(12'h181, 12'hFFF);
      i_far.send(8'h00, 1'b0, 1'b0, 1'b0);
      pop(12'h500, 12'hFFF);
      @(posedge i_ref_clk) i_parity_en <= 1'b1;
      i_far.send(8'h07, 1'b1, 1'b0, 1'b1);
      pop(12'h207, 12'hFFF);
      i_far.send(8'h07, 1'b1, 1'b1, 1'b1);
      pop(12'h007, 12'hFFF);
      @(posedge i_ref_clk) i_parity_en <= 1'b0;
      $display("receive checks done");
    end
  endtask
  task t_overrun;
    begin
      @(posedge i_ref_clk) i_fifo_en <= 1'b0;
      i_far.send(8'h11, 1'b0, 1'b0, 1'b1);
      i_far.send(8'h22, 1'b0, 1'b0, 1'b1);
      check("overrun", {11'h000, o_overrun_pending}, 12'h001);
      pop(12'h011, 12'hFFF);
      i_far.send(8'h33, 1'b0, 1'b0, 1'b1);
      pop(12'h833, 12'hFFF);
      check("overrun", {11'h000, o_overrun_pending}, 12'h000);
      @(posedge i_ref_clk) i_fifo_en <= 1'b1;
      $display("overrun done");
    end
  endtask
  task t_fill;
    integer n;
    begin
      @(posedge i_ref_clk) i_tx_enable <= 1'b0;
      @(posedge i_ref_clk) i_tx_valid <= 1'b1;
      i_tx_data <= 8'h55;
      n = 0;
      @(negedge i_ref_clk);
      while (o_tx_ready === 1'b1 && n < 40) begin
        n = n + 1;
        @(negedge i_ref_clk);
      end
      @(posedge i_ref_clk) i_tx_valid <= 1'b0;
      check("fill count", n[11:0], 12'h020);
      check("busy", {11'h000, o_busy}, 12'h001);
      @(posedge i_ref_clk) i_tx_enable <= 1'b1;
      wait_idle;
      $display("transmit fill done");
    end
  endtask
  task width(input integer lo, input integer hi);
    integer k;
    integer h;
    begin
      k = 0;
      h = 0;
      @(negedge i_ref_clk);
      while (o_ir_tx_out_n !== 1'b1 && k < 4000) begin
        @(negedge i_ref_clk);
        k = k + 1;
      end
      while (o_ir_tx_out_n === 1'b1 && h < 200) begin
        @(negedge i_ref_clk);
        h = h + 1;
      end
      check("ir pulse ok", {11'h000, h >= lo && h <= hi}, 12'h001);
    end
  endtask
  task t_ir;
    begin
      @(posedge i_ref_clk) i_ir_en <= 1'b1;
      push(8'hFF);
      width(6, 6);
      wait_idle;
      @(posedge i_ref_clk) i_ir_lowpower_select <= 1'b1;
      push(8'hFF);
      width(45, 66);
      wait_idle;
      @(posedge i_ref_clk) i_ir_lowpower_select <= 1'b0;
      i_ir_en <= 1'b0;
      i_loopback_enable <= 1'b1;
      push(8'hC3);
      pop(12'h0C3, 12'hFFF);
      wait_idle;
      @(posedge i_ref_clk) i_ir_en <= 1'b1;
      i_ir_test_loop <= 1'b1;
      push(8'h96);
      pop(12'h096, 12'hFFF);
      wait_idle;
      @(posedge i_ref_clk) i_ir_en <= 1'b0;
      i_ir_test_loop <= 1'b0;
      i_loopback_enable <= 1'b0;
      $display("infrared and loopback done");
    end
  endtask
  task t_opts;
    integer n;
    begin
      @(posedge i_ref_clk) i_parity_en <= 1'b1;
      i_parity_stick <= 1'b1;
      i_parity_even <= 1'b0;
      i_far.send(8'h07, 1'b1, 1'b0, 1'b1);
      pop(12'h207, 12'hFFF);
      @(posedge i_ref_clk) i_parity_stick <= 1'b0;
      i_far.send(8'h07, 1'b1, 1'b0, 1'b1);
      pop(12'h007, 12'hFFF);
      @(posedge i_ref_clk) i_parity_en <= 1'b0;
      i_parity_even <= 1'b1;
      i_send_break <= 1'b1;
      repeat (2) @(negedge i_ref_clk);
      check("break out", {11'h000, o_serial_tx_out}, 12'h000);
      @(posedge i_ref_clk) i_send_break <= 1'b0;
      i_two_stop <= 1'b1;
      push(8'hFF);
      // Eleven bit times of 32 clocks, plus the pop and tick phase
      n = 1;
      @(negedge i_ref_clk);
      while (o_busy === 1'b1 && n < 400) begin
        @(negedge i_ref_clk);
        n = n + 1;
      end
      check("two stop", {11'h000, n > 350 && n < 357}, 12'h001);
      @(posedge i_ref_clk) i_two_stop <= 1'b0;
      i_ir_en <= 1'b1;
      i_ir_lowpower_select <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      i_ir_rx_in <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_ir_rx_in <= 1'b1;
      repeat (400) @(negedge i_ref_clk);
      check("ir glitch", {11'h000, o_rx_valid}, 12'h000);
      @(posedge i_ref_clk) i_ir_en <= 1'b0;
      i_ir_lowpower_select <= 1'b0;
      $display("line options done");
    end
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_tx;
    t_rx;
    t_overrun;
    t_fill;
    t_ir;
    t_opts;
    test_done;
  end
endmodule // tb_urir_core
